/* design/gate_pkg.sv */
// constants, types and register map of the battery power-control gate
// How it works
// - without main power, any low wake, high override or gated alarm raises output
// - main power good with source select clear: output follows the external OR
// - main power good, select and firmware value set: output forced high
// - select set, firmware value clear: output held low while main power stays
// - main power lost: output returns to the external inputs, register ignored
// - control register reachable only while main power good is high
// - controller reads wake, override and output levels in the control register
// - external mode output low only with override low, wakes high, alarm idle
// - alarm term counts only while alarm output and alarm enable both high
// - asserted override makes wake inputs irrelevant to the output
// - controller can enable interrupts from override and wake pins
// - override and wake pins can raise wake events for the controller
// - control register: 8 bits at 00h, bits 7:6 read/write, bits 5:0 read-only
// - source select one follows firmware value, zero follows external inputs
// - override and each wake pin own a bit of one interrupt status register
package gate_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 4;
  localparam int WAKE_N = 4;
  localparam int PIN_N = 5;
  typedef logic [ADDR_W-1:0] reg_addr_type;
  typedef logic [DATA_W-1:0] reg_data_type;
  typedef logic [PIN_N-1:0] pin_vec_type;
  localparam reg_addr_type CTRL_OFS = 4'h0;
  localparam reg_addr_type IRQ_STATUS_OFS = 4'h1;
  localparam reg_addr_type IRQ_MASK_OFS = 4'h2;
  localparam reg_addr_type RISE_EN_OFS = 4'h3;
  localparam reg_addr_type FALL_EN_OFS = 4'h4;
  localparam reg_addr_type WAKE_EN_OFS = 4'h5;
  localparam int SRC_SEL_BIT = 7;
  localparam int FW_VALUE_BIT = 6;
  localparam int OUT_BIT = 5;
  localparam int OVRD_BIT = 4;
  localparam logic CTRL_BIT_RESET = 1'b0;
  localparam pin_vec_type VEC_RESET = 5'h00;
  localparam reg_data_type RDATA_IDLE = 8'h00;
  // pin status layout: the four wake levels above override, the reverse of the control register
  typedef struct packed {
    logic [WAKE_N-1:0] wake_n;
    logic override;
    logic main_power_good;
    logic system_reset_n;
    logic power_enable;
  } pin_bundle_type;
  // wakes idle high, everything else low until the synchroniser fills
  localparam pin_bundle_type PIN_RESET = 8'hf0;
  typedef struct packed {
    reg_addr_type addr;
    reg_data_type wdata;
    logic wr;
    logic rd;
  } bus_req_type;
endpackage

/* design/pin_sync.sv */
// two-stage synchroniser for the pin status bundle
`timescale 1ns/1ns
`default_nettype none
module pin_sync (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire gate_pkg::pin_bundle_type pins_in,
  output gate_pkg::pin_bundle_type pins_out
);
  import gate_pkg::*;
  typedef struct packed {
    pin_bundle_type stage1;
    pin_bundle_type stage2;
  } sync_state_type;
  sync_state_type st;
  sync_state_type next_st;
  // stage1 feeds stage2 only; nothing else may look at it
  always_comb begin
    next_st = st;
    next_st.stage1 = pins_in;
    next_st.stage2 = st.stage1;
  end
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st <= {PIN_RESET, PIN_RESET};
    end else begin
      st <= next_st;
    end
  end
  assign pins_out = st.stage2;
endmodule
`default_nettype wire

/* design/pin_edge_detect.sv */
// per-pin rising and falling edge detector for the interrupt pins
`timescale 1ns/1ns
`default_nettype none
module pin_edge_detect (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic enable_in,
  input wire gate_pkg::pin_vec_type level_in,
  input wire gate_pkg::pin_vec_type rise_en_in,
  input wire gate_pkg::pin_vec_type fall_en_in,
  output gate_pkg::pin_vec_type event_out
);
  import gate_pkg::*;
  typedef struct packed {
    pin_vec_type prev;
    logic armed;
    pin_vec_type events;
  } edge_state_type;
  edge_state_type st;
  edge_state_type next_st;
  always_comb begin
    next_st = st;
    next_st.prev = level_in;
    next_st.events = VEC_RESET;
    if (!enable_in) begin
      // re-arm only after one sample, so power-up levels never look like edges
      next_st.armed = 1'b0;
    end else begin
      next_st.armed = 1'b1;
      if (st.armed) begin
        next_st.events = (level_in & ~st.prev & rise_en_in) |
                         (~level_in & st.prev & fall_en_in);
      end
    end
  end
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st <= {PIN_RESET.override, PIN_RESET.wake_n, 1'b0, VEC_RESET};
    end else begin
      st <= next_st;
    end
  end
  assign event_out = st.events;
endmodule
`default_nettype wire

/* design/battery_power_control_gate.sv */
// battery power-control gate: output mux, control register and pin interrupts
`timescale 1ns/1ns
`default_nettype none
module battery_power_control_gate (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic system_reset_n_in,
  input wire logic main_power_good_in,
  input wire logic [gate_pkg::WAKE_N-1:0] wake_inputs_n_in,
  input wire logic override_input_in,
  input wire logic alarm_output_in,
  input wire logic alarm_power_enable_in,
  input wire gate_pkg::reg_addr_type reg_addr_in,
  input wire gate_pkg::reg_data_type reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output gate_pkg::reg_data_type reg_rdata_out,
  output logic irq_out,
  output logic wake_event_out,
  output logic power_enable_output_out
);
  import gate_pkg::*;

  typedef struct packed {
    logic src_sel;
    logic fw_value;
    pin_vec_type irq_status;
    pin_vec_type irq_mask;
    pin_vec_type rise_en;
    pin_vec_type fall_en;
    pin_vec_type wake_en;
    reg_data_type rdata;
  } gate_state_type;

  function automatic logic hit(input reg_addr_type a, input reg_addr_type ofs);
    return a == ofs;
  endfunction

  function automatic reg_data_type widen(input pin_vec_type v);
    return {3'h0, v};
  endfunction

  logic [1:0] rst_sync;
  logic rst_n;
  pin_bundle_type raw_pins;
  pin_bundle_type pins;
  pin_vec_type pin_levels;
  pin_vec_type events;
  bus_req_type req;
  gate_state_type st;
  gate_state_type next_st;
  logic access;
  logic alarm_term;
  logic ext_term;
  logic fw_owns;
  pin_vec_type clr;

  // reset release is synchronised; assertion of reset stays asynchronous
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  assign req = '{addr: reg_addr_in, wdata: reg_wdata_in, wr: reg_wr_in, rd: reg_rd_in};

  // the power path stays combinational from the pins so it works with no clock
  assign alarm_term = alarm_output_in & alarm_power_enable_in;
  // a high override alone decides, whatever the wake pins do
  assign ext_term = override_input_in | ~&wake_inputs_n_in | alarm_term;
  // raw power-good: losing main power hands the pin back at once, clock or not
  assign fw_owns = main_power_good_in & st.src_sel;
  assign power_enable_output_out = fw_owns ? st.fw_value : ext_term;

  assign raw_pins = '{
    wake_n: wake_inputs_n_in,
    override: override_input_in,
    main_power_good: main_power_good_in,
    system_reset_n: system_reset_n_in,
    power_enable: power_enable_output_out
  };

  pin_sync u_pin_sync (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n),
    .pins_in(raw_pins),
    .pins_out(pins)
  );

  assign pin_levels = {pins.override, pins.wake_n};
  // register well is unpowered without main power, and cleared by system reset
  assign access = pins.main_power_good & pins.system_reset_n;

  pin_edge_detect u_pin_edge_detect (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n),
    .enable_in(access),
    .level_in(pin_levels),
    .rise_en_in(st.rise_en),
    .fall_en_in(st.fall_en),
    .event_out(events)
  );

  always_comb begin
    next_st = st;
    clr = VEC_RESET;
    next_st.rdata = RDATA_IDLE;
    if (!access) begin
      next_st.src_sel = CTRL_BIT_RESET;
      next_st.fw_value = CTRL_BIT_RESET;
      next_st.irq_status = VEC_RESET;
      next_st.irq_mask = VEC_RESET;
      next_st.rise_en = VEC_RESET;
      next_st.fall_en = VEC_RESET;
      next_st.wake_en = VEC_RESET;
    end else begin
      if (req.wr) begin
        if (hit(req.addr, CTRL_OFS)) begin
          next_st.src_sel = req.wdata[SRC_SEL_BIT];
          next_st.fw_value = req.wdata[FW_VALUE_BIT];
        end
        if (hit(req.addr, IRQ_STATUS_OFS)) begin
          clr = req.wdata[PIN_N-1:0];
        end
        if (hit(req.addr, IRQ_MASK_OFS)) begin
          next_st.irq_mask = req.wdata[PIN_N-1:0];
        end
        if (hit(req.addr, RISE_EN_OFS)) begin
          next_st.rise_en = req.wdata[PIN_N-1:0];
        end
        if (hit(req.addr, FALL_EN_OFS)) begin
          next_st.fall_en = req.wdata[PIN_N-1:0];
        end
        if (hit(req.addr, WAKE_EN_OFS)) begin
          next_st.wake_en = req.wdata[PIN_N-1:0];
        end
      end
      // a new edge beats a simultaneous write-one-to-clear
      next_st.irq_status = (st.irq_status & ~clr) | events;
      if (req.rd) begin
        case (req.addr)
          CTRL_OFS: begin
            next_st.rdata = {st.src_sel, st.fw_value, pins.power_enable,
                             pin_levels};
          end
          IRQ_STATUS_OFS: begin
            next_st.rdata = widen(st.irq_status);
          end
          IRQ_MASK_OFS: begin
            next_st.rdata = widen(st.irq_mask);
          end
          RISE_EN_OFS: begin
            next_st.rdata = widen(st.rise_en);
          end
          FALL_EN_OFS: begin
            next_st.rdata = widen(st.fall_en);
          end
          WAKE_EN_OFS: begin
            next_st.rdata = widen(st.wake_en);
          end
          default: begin
            next_st.rdata = RDATA_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{
        src_sel: CTRL_BIT_RESET,
        fw_value: CTRL_BIT_RESET,
        irq_status: VEC_RESET,
        irq_mask: VEC_RESET,
        rise_en: VEC_RESET,
        fall_en: VEC_RESET,
        wake_en: VEC_RESET,
        rdata: RDATA_IDLE
      };
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata_out = st.rdata;
  assign irq_out = |(st.irq_status & st.irq_mask);
  assign wake_event_out = |(st.irq_status & st.wake_en);

  default clocking @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n);

  AST_EXT_WHEN_UNPOWERED: assert property (
    !main_power_good_in |-> power_enable_output_out ==
      (override_input_in | ~&wake_inputs_n_in |
       (alarm_output_in & alarm_power_enable_in))
  ) else $error("output does not follow external inputs without main power");

  AST_EXT_WHEN_SEL_CLEAR: assert property (
    main_power_good_in && !st.src_sel |-> power_enable_output_out ==
      (override_input_in | ~&wake_inputs_n_in |
       (alarm_output_in & alarm_power_enable_in))
  ) else $error("output does not follow external inputs with select clear");

  AST_FW_DRIVES_HIGH: assert property (
    main_power_good_in && st.src_sel && st.fw_value |-> power_enable_output_out
  ) else $error("firmware high value not driven");

  AST_FW_HOLDS_LOW: assert property (
    main_power_good_in && st.src_sel && !st.fw_value
      |-> !power_enable_output_out
  ) else $error("firmware low value not driven");

  AST_POWER_LOSS_RETURNS: assert property (
    $fell(main_power_good_in) && !override_input_in && &wake_inputs_n_in &&
      !alarm_output_in |-> !power_enable_output_out
  ) else $error("register still steers output after power loss");

  AST_LOW_NEEDS_ALL_IDLE: assert property (
    !power_enable_output_out && !(main_power_good_in && st.src_sel)
      |-> !override_input_in && &wake_inputs_n_in &&
          !(alarm_output_in && alarm_power_enable_in)
  ) else $error("output low while an external input is active");

  AST_ALARM_GATED: assert property (
    !main_power_good_in && !override_input_in && &wake_inputs_n_in &&
      alarm_output_in && !alarm_power_enable_in |-> !power_enable_output_out
  ) else $error("alarm passed without alarm enable");

  AST_OVERRIDE_DOMINATES: assert property (
    override_input_in && !(main_power_good_in && st.src_sel)
      |-> power_enable_output_out
  ) else $error("override high but output low");

  AST_NO_ACCESS_UNPOWERED: assert property (
    !pins.main_power_good |=> !st.src_sel && !st.fw_value &&
      reg_rdata_out == RDATA_IDLE
  ) else $error("control register reachable without main power");

  AST_CTRL_WRITE_TAKES: assert property (
    reg_wr_in && hit(reg_addr_in, CTRL_OFS) && access
      |=> st.src_sel == $past(reg_wdata_in[SRC_SEL_BIT]) &&
          st.fw_value == $past(reg_wdata_in[FW_VALUE_BIT])
  ) else $error("control write not stored");

  AST_STATUS_READBACK: assert property (
    reg_rd_in && hit(reg_addr_in, CTRL_OFS) && access
      |=> reg_rdata_out[OVRD_BIT:0] == $past(pin_levels) &&
          reg_rdata_out[OUT_BIT] == $past(pins.power_enable)
  ) else $error("pin status read wrong");

  AST_READ_ONE_CYCLE: assert property (
    !reg_rd_in |=> reg_rdata_out == RDATA_IDLE
  ) else $error("read data outside its cycle");

  AST_STICKY_SET_WINS: assert property (
    access && (events != VEC_RESET)
      |=> (st.irq_status & $past(events)) == $past(events) ##1
          ((st.irq_status & $past(events, 2)) == $past(events, 2) || !$past(access) ||
           $past(reg_wr_in) || !access)
  ) else $error("edge event lost");

  AST_IRQ_ON_MASKED_EVENT: assert property (
    access && ((events & st.irq_mask) != VEC_RESET) && !reg_wr_in |=> irq_out
  ) else $error("enabled event did not raise interrupt");

  AST_WAKE_ON_EVENT: assert property (
    access && ((events & st.wake_en) != VEC_RESET) && !reg_wr_in
      |=> wake_event_out
  ) else $error("enabled event did not raise wake");

  AST_SYNC_LATENCY: assert property (
    ($stable(override_input_in) && $past(rst_n, 3)) [*3]
      |-> pins.override == override_input_in
  ) else $error("override status not synchronised in two cycles");

  AST_EVENTS_NEED_ACCESS: assert property (
    !access |=> st.irq_status == VEC_RESET && !irq_out && !wake_event_out
  ) else $error("interrupt state kept without register access");

  AST_NO_EDGE_ON_ARMING: assert property (
    $rose(access) |-> events == VEC_RESET ##1 events == VEC_RESET
  ) else $error("false edge when register access returns");

  AST_STATUS_STICKY: assert property (
    access && !reg_wr_in
      |=> (st.irq_status & $past(st.irq_status)) == $past(st.irq_status)
  ) else $error("status bit dropped without a clear");

  AST_STATUS_CLEAR_ONE: assert property (
    access && reg_wr_in && hit(reg_addr_in, IRQ_STATUS_OFS)
      |=> (st.irq_status & $past(reg_wdata_in[PIN_N-1:0]) & ~$past(events)) == VEC_RESET
  ) else $error("write one did not clear status");

  AST_MASK_WRITE_TAKES: assert property (
    reg_wr_in && hit(reg_addr_in, IRQ_MASK_OFS) && access
      |=> st.irq_mask == $past(reg_wdata_in[PIN_N-1:0])
  ) else $error("mask write not stored");

  AST_IRQ_CLEARED_BY_MASK: assert property (
    reg_wr_in && hit(reg_addr_in, IRQ_MASK_OFS) && access &&
      reg_wdata_in[PIN_N-1:0] == VEC_RESET |=> !irq_out
  ) else $error("interrupt high with every source masked");

  AST_RISE_EN_WRITE_TAKES: assert property (
    reg_wr_in && hit(reg_addr_in, RISE_EN_OFS) && access
      |=> st.rise_en == $past(reg_wdata_in[PIN_N-1:0])
  ) else $error("rising edge enable write not stored");

  AST_FALL_EN_WRITE_TAKES: assert property (
    reg_wr_in && hit(reg_addr_in, FALL_EN_OFS) && access
      |=> st.fall_en == $past(reg_wdata_in[PIN_N-1:0])
  ) else $error("falling edge enable write not stored");

  AST_WAKE_EN_WRITE_TAKES: assert property (
    reg_wr_in && hit(reg_addr_in, WAKE_EN_OFS) && access
      |=> st.wake_en == $past(reg_wdata_in[PIN_N-1:0])
  ) else $error("wake enable write not stored");

  AST_UNMAPPED_READS_ZERO: assert property (
    reg_rd_in && reg_addr_in > WAKE_EN_OFS |=> reg_rdata_out == RDATA_IDLE
  ) else $error("unmapped address read not zero");

  AST_UPPER_BITS_ZERO: assert property (
    reg_rd_in && !hit(reg_addr_in, CTRL_OFS) |=> reg_rdata_out[DATA_W-1:PIN_N] == 3'h0
  ) else $error("unused upper bits read nonzero");

  AST_SYSTEM_RESET_CLEARS: assert property (
    !pins.system_reset_n |=> !st.src_sel && !st.fw_value &&
      st.irq_mask == VEC_RESET && st.wake_en == VEC_RESET
  ) else $error("system reset did not clear the registers");

  COV_FW_TAKEOVER: cover property (
    main_power_good_in && st.fw_value ##1 st.src_sel && power_enable_output_out
  );
  COV_FW_SHUTDOWN: cover property (
    main_power_good_in && st.src_sel && !st.fw_value && !override_input_in ##1
      !main_power_good_in
  );
  COV_IRQ_RAISED: cover property ($rose(irq_out));
  COV_WAKE_RAISED: cover property ($rose(wake_event_out));
  COV_POWER_LOSS_HANDBACK: cover property (
    $fell(main_power_good_in) && st.src_sel && power_enable_output_out
  );
endmodule
`default_nettype wire

/* tb/pin_partner.sv */
// behavioural model of the pin side: buttons, charger detect and supply switch
`timescale 1ns/1ns
`default_nettype none
module pin_partner (
  input wire logic [3:0] press_in,
  input wire logic charger_in,
  input wire logic supply_in,
  output logic [3:0] wake_inputs_n_out,
  output logic override_input_out,
  output logic main_power_good_out
);
  // a pressed button pulls its line low; released lines idle high on their pull-ups
  assign wake_inputs_n_out = ~press_in;
  assign override_input_out = charger_in;
  // supply switch only reports good while the main rail is really up
  assign main_power_good_out = supply_in;
endmodule
`default_nettype wire

/* tb/battery_power_control_gate_tb.sv */
// self-checking bench for the battery power-control gate
`timescale 1ns/1ns
`default_nettype none
module battery_power_control_gate_tb;
  import gate_pkg::*;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic sys_rst_n = 1'b1;
  logic [3:0] press = 4'h0;
  logic charger = 1'b0;
  logic supply = 1'b1;
  logic alarm = 1'b0;
  logic alarm_en = 1'b0;
  reg_addr_type addr = 4'h0;
  reg_data_type wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_seen = 1'b0;
  wire logic [3:0] wake_n;
  wire logic ovrd;
  wire logic mpg;
  reg_data_type rdata;
  logic irq;
  logic wake_ev;
  logic pe;
  reg_data_type exp_q[$];
  int failures = 0;
  int total_checks = 0;
  logic expect_pe;

  always #5 sys_clk = ~sys_clk;

  pin_partner partner (
    .press_in(press), .charger_in(charger), .supply_in(supply),
    .wake_inputs_n_out(wake_n), .override_input_out(ovrd), .main_power_good_out(mpg)
  );

  battery_power_control_gate DUT (
    .sys_clk_in(sys_clk), .rstn_in(rstn), .system_reset_n_in(sys_rst_n),
    .main_power_good_in(mpg), .wake_inputs_n_in(wake_n), .override_input_in(ovrd),
    .alarm_output_in(alarm), .alarm_power_enable_in(alarm_en),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .irq_out(irq), .wake_event_out(wake_ev),
    .power_enable_output_out(pe)
  );

  task automatic conclude();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr_reg(input reg_addr_type a, input reg_data_type d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask

  // the expected word is noted here and compared by the read monitor
  task automatic rd_reg(input reg_addr_type a, input reg_data_type exp);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(exp);
    @(posedge sys_clk);
    rd <= 1'b0;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  // read data stand only in the cycle after the strobe, so sample mid-cycle there
  always @(posedge sys_clk) rd_seen <= rd;
  always @(negedge sys_clk) begin
    if (rd_seen) begin
      if (exp_q.size() == 0) begin
        check("read queue", 8'h01, 8'h00);
      end else begin
        check("reg_rdata_out", rdata, exp_q.pop_front());
      end
    end
  end

  task automatic wait_irq();
    int i;
    for (i = 0; i < 10 && irq !== 1'b1; i++) @(negedge sys_clk);
    if (irq !== 1'b1) begin
      check("irq_out timeout", 8'(irq), 8'h01);
      conclude();
    end
  endtask

  initial begin
    void'($urandom(54302));
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    cycles(6);
    // external mode across random pins, with and without main power
    repeat (48) begin
      @(posedge sys_clk);
      press <= 4'($urandom_range(0, 1) ? $urandom : 0);
      charger <= 1'($urandom);
      alarm <= 1'($urandom);
      alarm_en <= 1'($urandom);
      supply <= 1'($urandom);
      @(negedge sys_clk);
      expect_pe = charger | (|press) | (alarm & alarm_en);
      check("pe external", 8'(pe), 8'(expect_pe));
    end
    @(posedge sys_clk);
    {press, charger, alarm, alarm_en, supply} <= 8'h01;
    cycles(6);
    rd_reg(CTRL_OFS, 8'h0f);
    @(posedge sys_clk);
    charger <= 1'b1;
    press <= 4'b0010;
    cycles(4);
    rd_reg(CTRL_OFS, 8'h3d);
    // value before select avoids a low glitch on handover
    wr_reg(CTRL_OFS, 8'h40);
    wr_reg(CTRL_OFS, 8'hc0);
    @(posedge sys_clk);
    charger <= 1'b0;
    press <= 4'h0;
    cycles(4);
    check("pe forced high", 8'(pe), 8'h01);
    rd_reg(CTRL_OFS, 8'hef);
    wr_reg(CTRL_OFS, 8'h80);
    @(posedge sys_clk);
    charger <= 1'b1;
    cycles(1);
    check("pe forced low", 8'(pe), 8'h00);
    @(posedge sys_clk);
    supply <= 1'b0;
    cycles(1);
    check("pe after power loss", 8'(pe), 8'h01);
    cycles(4);
    rd_reg(CTRL_OFS, 8'h00);
    wr_reg(CTRL_OFS, 8'h80);
    @(posedge sys_clk);
    supply <= 1'b1;
    cycles(6);
    rd_reg(CTRL_OFS, 8'h3f);
    wr_reg(CTRL_OFS, 8'h80);
    @(posedge sys_clk);
    sys_rst_n <= 1'b0;
    cycles(4);
    check("pe under system reset", 8'(pe), 8'h01);
    @(posedge sys_clk);
    sys_rst_n <= 1'b1;
    charger <= 1'b0;
    cycles(6);
    wr_reg(4'h9, 8'hff);
    rd_reg(4'h9, 8'h00);
    // pin interrupts: wake line falling, then override rising
    wr_reg(IRQ_MASK_OFS, 8'h1f);
    wr_reg(FALL_EN_OFS, 8'h1f);
    wr_reg(WAKE_EN_OFS, 8'h1f);
    cycles(4);
    check("irq idle", 8'(irq), 8'h00);
    @(posedge sys_clk);
    press <= 4'b0001;
    wait_irq();
    rd_reg(IRQ_STATUS_OFS, 8'h01);
    cycles(0);
    check("wake event", 8'(wake_ev), 8'h01);
    wr_reg(IRQ_STATUS_OFS, 8'h01);
    cycles(1);
    check("irq after clear", 8'(irq), 8'h00);
    wr_reg(RISE_EN_OFS, 8'h1f);
    @(posedge sys_clk);
    charger <= 1'b1;
    wait_irq();
    rd_reg(IRQ_STATUS_OFS, 8'h10);
    wr_reg(IRQ_MASK_OFS, 8'h00);
    cycles(1);
    check("irq masked", 8'(irq), 8'h00);
    check("wake event unmasked", 8'(wake_ev), 8'h01);
    cycles(3);
    conclude();
  end
endmodule
`default_nettype wire
